// File: ptm_pkg.sv
// Purpose: constants for the 8-bit period timer
// Assumes: AXI4-Lite, 32-bit data, registers in the low byte of a word
// Notes: offsets are indices; the byte address is four times the index
package ptm_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD_VALUE = 8'h92;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam int unsigned CTL_PRESCALE_LSB = 0;
  localparam int unsigned CTL_RUN_BIT = 2;
  localparam int unsigned CTL_POSTSCALE_LSB = 3;
  localparam int unsigned MATCH_FLAG_BIT = 1;
  localparam logic [1:0] OSC_DIV_LAST = 2'h3;
  localparam logic [3:0] PRESCALE_LAST_1 = 4'h0;
  localparam logic [3:0] PRESCALE_LAST_4 = 4'h3;
  localparam logic [3:0] PRESCALE_LAST_16 = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: ptm_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and AXI4-Lite registers
// Assumes: clock is the oscillator; one instruction cycle per four clocks
// Notes: flag and enable registers hold only the period-match bits; others read zero
`timescale 1ns/1ps

module ptm_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [ptm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ptm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sync serial port shift clock source
  output logic sync_serial_port_tick,
  // pwm time base for the capture_compare_pwm_unit
  output logic [7:0] pwm_time_base,
  output logic pwm_period_match,
  // interrupt request
  output logic period_match_irq
);
  import ptm_pkg::*;

  logic [7:0] timer_count_q;
  logic [7:0] period_value_q;
  logic [6:0] timer_control_q;
  logic period_match_flag_q;
  logic period_match_irq_en_q;
  logic [1:0] osc_div_q;
  logic [3:0] prescale_q;
  logic [3:0] postscale_q;
  logic match_pulse_q;

  // write and read channel holding registers
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // word index of a byte address, or an out-of-range marker
  function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != 2'h0) begin
      return 9'h100;
    end
    return {1'b0, addr[9:2]} | {addr[ADDR_W-1:10] != '0, 8'h00};
  endfunction

  function automatic logic known_index(input logic [8:0] idx);
    return idx == {1'b0, IDX_PERIPHERAL_FLAGS} || idx == {1'b0, IDX_TIMER_COUNT} ||
           idx == {1'b0, IDX_TIMER_CONTROL} || idx == {1'b0, IDX_PERIPHERAL_IRQ_ENABLES} ||
           idx == {1'b0, IDX_PERIOD_VALUE};
  endfunction

  // write decode: fire once both address and data are held and no response waits
  logic wr_fire;
  logic [8:0] wr_idx;
  logic wr_lane0;
  logic wr_count;
  logic wr_control;
  logic wr_period;
  logic wr_flags;
  logic wr_enables;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = word_index(awaddr_q);
  assign wr_lane0 = wr_fire && wstrb_q[0];
  assign wr_count = wr_lane0 && wr_idx == {1'b0, IDX_TIMER_COUNT};
  assign wr_control = wr_lane0 && wr_idx == {1'b0, IDX_TIMER_CONTROL};
  assign wr_period = wr_lane0 && wr_idx == {1'b0, IDX_PERIOD_VALUE};
  assign wr_flags = wr_lane0 && wr_idx == {1'b0, IDX_PERIPHERAL_FLAGS};
  assign wr_enables = wr_lane0 && wr_idx == {1'b0, IDX_PERIPHERAL_IRQ_ENABLES};

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= known_index(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read path: data captured on the address handshake, answered next cycle
  logic [8:0] rd_idx;
  logic [7:0] rd_byte;
  assign rd_idx = word_index(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == {1'b0, IDX_TIMER_COUNT}) begin
      rd_byte = timer_count_q;
    end else if (rd_idx == {1'b0, IDX_TIMER_CONTROL}) begin
      rd_byte = {1'b0, timer_control_q};
    end else if (rd_idx == {1'b0, IDX_PERIOD_VALUE}) begin
      rd_byte = period_value_q;
    end else if (rd_idx == {1'b0, IDX_PERIPHERAL_FLAGS}) begin
      rd_byte = 8'(period_match_flag_q) << MATCH_FLAG_BIT;
    end else if (rd_idx == {1'b0, IDX_PERIPHERAL_IRQ_ENABLES}) begin
      rd_byte = 8'(period_match_irq_en_q) << MATCH_FLAG_BIT;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= known_index(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_control_q <= RST_CONTROL;
    end else if (wr_control) begin
      timer_control_q <= wdata_q[6:0];
    end
  end

  logic [1:0] input_prescale_sel;
  logic timer_run;
  logic [3:0] output_postscale_sel;
  assign input_prescale_sel = timer_control_q[CTL_PRESCALE_LSB +: 2];
  assign timer_run = timer_control_q[CTL_RUN_BIT];
  assign output_postscale_sel = timer_control_q[CTL_POSTSCALE_LSB +: 4];

  logic [3:0] prescale_last;
  always_comb begin
    unique case (input_prescale_sel)
      2'b00: prescale_last = PRESCALE_LAST_1;
      2'b01: prescale_last = PRESCALE_LAST_4;
      default: prescale_last = PRESCALE_LAST_16;
    endcase
  end

  // instruction cycle strobe, then prescaler; both cleared by scaler-clearing writes
  logic scaler_clear;
  logic inst_tick;
  logic count_tick;
  assign scaler_clear = wr_count || wr_control;
  assign inst_tick = timer_run && osc_div_q == OSC_DIV_LAST;
  assign count_tick = inst_tick && prescale_q >= prescale_last;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_div_q <= 2'h0;
    end else if (scaler_clear || !timer_run) begin
      osc_div_q <= 2'h0;
    end else begin
      osc_div_q <= osc_div_q + 2'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_q <= 4'h0;
    end else if (scaler_clear || count_tick) begin
      prescale_q <= 4'h0;
    end else if (inst_tick) begin
      prescale_q <= prescale_q + 4'h1;
    end
  end

  // counter: a write wins over a tick; control writes do not touch it
  logic at_period;
  assign at_period = timer_count_q == period_value_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_count_q <= RST_COUNT;
    end else if (wr_count) begin
      timer_count_q <= wdata_q[7:0];
    end else if (count_tick) begin
      timer_count_q <= at_period ? 8'h00 : timer_count_q + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      period_value_q <= RST_PERIOD;
    end else if (wr_period) begin
      period_value_q <= wdata_q[7:0];
    end
  end

  // match pulse: one cycle when a tick finds the counter at the period value, unless a count write wins
  logic match_event;
  assign match_event = count_tick && at_period && !wr_count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      match_pulse_q <= 1'b0;
    end else begin
      match_pulse_q <= match_event;
    end
  end

  assign sync_serial_port_tick = match_pulse_q;
  assign pwm_period_match = match_pulse_q;
  assign pwm_time_base = timer_count_q;

  // postscaler
  logic post_event;
  assign post_event = match_event && postscale_q >= output_postscale_sel;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      postscale_q <= 4'h0;
    end else if (scaler_clear || post_event) begin
      postscale_q <= 4'h0;
    end else if (match_event) begin
      postscale_q <= postscale_q + 4'h1;
    end
  end

  // set wins over a simultaneous software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      period_match_flag_q <= RST_FLAGS[MATCH_FLAG_BIT];
    end else if (post_event) begin
      period_match_flag_q <= 1'b1;
    end else if (wr_flags) begin
      period_match_flag_q <= wdata_q[MATCH_FLAG_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      period_match_irq_en_q <= RST_ENABLES[MATCH_FLAG_BIT];
    end else if (wr_enables) begin
      period_match_irq_en_q <= wdata_q[MATCH_FLAG_BIT];
    end
  end

  assign period_match_irq = period_match_flag_q && period_match_irq_en_q;
endmodule

// File: ptm_timer_chk.sv
// Purpose: port-level checks for the period timer
// Assumes: single clock domain, async active-high reset
// Notes: tracks only whether the last read targeted the control register
`timescale 1ns/1ps
module ptm_timer_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ptm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // timer outputs
  input wire logic sync_serial_port_tick,
  input wire logic pwm_period_match,
  input wire logic period_match_irq
);
  import ptm_pkg::*;
  logic rd_ctl_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rd_ctl_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) rd_ctl_q <= s_axi_araddr == {2'h0, IDX_TIMER_CONTROL, 2'h0};
  end
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  property p_wr; (s_aw and s_w) |-> ##2 s_axi_bvalid; endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_ctl7; s_axi_rvalid && rd_ctl_q |-> !s_axi_rdata[7]; endproperty
  property p_ssp; sync_serial_port_tick == pwm_period_match; endproperty
  property p_gap; pwm_period_match |=> !pwm_period_match [*3]; endproperty
  // the flag rises near a match or through a write, the enable only through a write
  property p_rise;
    $rose(period_match_irq) |-> s_axi_bvalid || pwm_period_match ||
      $past(pwm_period_match) || $past(pwm_period_match, 2) || $past(pwm_period_match, 3);
  endproperty
  property p_fall; $fell(period_match_irq) |-> s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  a_rd: assert property (p_rd) else $error("read not answered");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_ctl7: assert property (p_ctl7) else $error("control bit 7 set");
  a_ssp: assert property (p_ssp) else $error("serial tick differs");
  a_gap: assert property (p_gap) else $error("matches too close");
  a_rise: assert property (p_rise) else $error("irq rose unprompted");
  a_fall: assert property (p_fall) else $error("irq fell unprompted");
endmodule
bind ptm_timer ptm_timer_chk chk_u (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .sync_serial_port_tick,
  .pwm_period_match, .period_match_irq);

// File: test_ptm_timer.sv
// Purpose: register-level tests of the period timer
// Assumes: byte address is four times the register index
// Notes: count-write clearing of the scalers is left unchecked
`timescale 1ns/1ps
module test_ptm_timer;
  import ptm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awa = '0;
  logic [ADDR_W-1:0] ara = '0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0] wd = '0;
  logic awr, wr, bv, arr, rv, pm, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  logic [7:0] tbase;
  int err_count = 0, checked = 0, pulses = 0, k;
  time t0;
  always #10 clock = ~clock;
  always @(posedge clock) if (pm) pulses <= pulses + 1;
  ptm_timer dut_u (.clock, .rst, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .sync_serial_port_tick(),
    .pwm_time_base(tbase), .pwm_period_match(pm), .period_match_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    logic a = 1'b0;
    logic w = 1'b0;
    logic b = 1'b0;
    logic [1:0] r = 2'h0;
    @(posedge clock);
    awa <= {2'h0, idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    // sample the slave mid-cycle so the values are those seen at the next edge
    do begin
      @(negedge clock);
      a = awr;
      w = wr;
      b = bv;
      r = bresp;
      @(posedge clock);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end while (b !== 1'b1 && ++n < 40);
    br <= 1'b0;
    chk(b, 1'b1);
    chk(r, er);
  endtask
  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    logic a = 1'b0;
    logic v = 1'b0;
    logic [1:0] r = 2'h0;
    logic [31:0] dat = '0;
    @(posedge clock);
    ara <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(negedge clock);
      a = arr;
      v = rv;
      r = rresp;
      dat = rdat;
      @(posedge clock);
      if (a) arv <= 1'b0;
    end while (v !== 1'b1 && ++n < 40);
    rr <= 1'b0;
    chk(v, 1'b1);
    chk(r, er);
    chk(dat, {24'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rreg(IDX_TIMER_COUNT, RST_COUNT);
    rreg(IDX_PERIOD_VALUE, RST_PERIOD);
    rreg(IDX_TIMER_CONTROL, 8'h00);
    rreg(IDX_PERIPHERAL_FLAGS, RST_FLAGS);
    rreg(IDX_PERIPHERAL_IRQ_ENABLES, RST_ENABLES);
    rreg(8'h13, 8'h00, RESP_SLVERR);
    wreg(8'h13, 8'h55, RESP_SLVERR);
    wreg(IDX_TIMER_CONTROL, 8'hfb);
    rreg(IDX_TIMER_CONTROL, 8'h7b);
    wreg(IDX_PERIOD_VALUE, 8'h5a);
    rreg(IDX_PERIOD_VALUE, 8'h5a);
    wreg(IDX_TIMER_COUNT, 8'h03);
    repeat (100) @(posedge clock);
    rreg(IDX_TIMER_COUNT, 8'h03);
    wreg(IDX_TIMER_CONTROL, 8'h06);
    rreg(IDX_TIMER_COUNT, 8'h03);
    // spacing of increments for every prescale code
    for (int c = 0; c < 4; c++) begin
      wreg(IDX_TIMER_CONTROL, {5'h01, c[1:0]});
      @(tbase);
      t0 = $time;
      @(tbase);
      chk(32'(($time - t0) / 20), c == 0 ? 4 : c == 1 ? 16 : 64);
    end
    // prescale is still 16 here: three counts of 64 clocks per wrap
    wreg(IDX_PERIOD_VALUE, 8'h02);
    wreg(IDX_TIMER_COUNT, 8'h00);
    @(posedge pm);
    t0 = $time;
    @(posedge pm);
    chk(32'(($time - t0) / 20), 192);
    wreg(IDX_PERIOD_VALUE, 8'h00);
    wreg(IDX_PERIPHERAL_IRQ_ENABLES, 8'h02);
    for (int p = 0; p < 16; p += 5) begin
      wreg(IDX_TIMER_CONTROL, 8'h00);
      wreg(IDX_PERIPHERAL_FLAGS, 8'h00);
      wreg(IDX_TIMER_COUNT, 8'h00);
      wreg(IDX_TIMER_CONTROL, {1'b0, p[3:0], 3'h4});
      pulses = 0;
      for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clock);
      // let the pulse counter take the last match; the next is four clocks away
      repeat (2) @(negedge clock);
      chk(pulses, p + 1);
    end
    repeat (100) @(posedge clock);
    chk(irq, 1'b1);
    wreg(IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
    chk(irq, 1'b0);
    rreg(IDX_PERIPHERAL_FLAGS, 8'h02);
    wreg(IDX_TIMER_CONTROL, 8'h00);
    wreg(IDX_PERIPHERAL_FLAGS, 8'h00);
    rreg(IDX_PERIPHERAL_FLAGS, 8'h00);
    tally_and_finish();
  end
  // the whole sequence needs well under 20000 cycles
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule
